// ---- rtl/eepc_top.v ----
// Register access over APB and the placing of the registers were chosen for this implementation.
`include "eepc_regs.vh"

module eepc_top #(
    parameter integer PGM_CYC = `EEPC_PGM_PULSE_US * 1000 / `EEPC_CLK_NS,
    parameter integer BYTE_CYC = `EEPC_BYTE_ERASE_US * 1000 / `EEPC_CLK_NS,
    parameter integer BLOCK_CYC = `EEPC_BLOCK_ERASE_US * 1000 / `EEPC_CLK_NS,
    parameter integer BULK_CYC = `EEPC_BULK_ERASE_US * 1000 / `EEPC_CLK_NS,
    parameter integer CW = 24
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg hv_pump_on
);

////////////////////////////////////////////////////////////////////////////
// Bus decode.

wire fire = psel & penable & pready;
wire wr = fire & pwrite;
wire rd = fire & ~pwrite;
wire arr_hit = paddr[`EEPC_ARR_SEL_BIT];
// Address bits below the word index are ignored, so any byte lane of a
// register word selects that register.
wire [8:0] idx = paddr[`EEPC_IDX_HI:`EEPC_IDX_LO];
wire [11:0] ofs_ctrl = `EEPC_OFS_CTRL;
wire [11:0] ofs_shadow = `EEPC_OFS_SHADOW;
wire [11:0] ofs_prot = `EEPC_OFS_PROT;
wire ctl_hit = ~arr_hit & (idx == ofs_ctrl[`EEPC_IDX_HI:`EEPC_IDX_LO]);
wire shd_hit = ~arr_hit & (idx == ofs_shadow[`EEPC_IDX_HI:`EEPC_IDX_LO]);
wire prt_hit = ~arr_hit & (idx == ofs_prot[`EEPC_IDX_HI:`EEPC_IDX_LO]);
wire mapped = arr_hit | ctl_hit | shd_hit | prt_hit;

////////////////////////////////////////////////////////////////////////////
// State.

reg [7:0] mem [0:`EEPC_DEPTH-1];
reg [7:0] shadow;
reg [3:0] block_protect_flag;
reg hv_pulse_enable;
reg auto_mode;
reg bus_latch_ctl;
reg op_mode_sel_lo;
reg op_mode_sel_hi;
reg fail;
reg lat_valid;
reg lat_shadow;
reg [8:0] lat_idx;
reg [7:0] lat_data;
reg spare;
reg [CW-1:0] cnt;

wire [1:0] mode = {op_mode_sel_hi, op_mode_sel_lo};

// The self-timed limit is three quarters of the manual time, so the
// hardware always finishes before software would have.
// The limits are worked out at full integer width and then cut to the
// counter, so CW must hold the longest manual time.
wire [31:0] pgm_lim_w = PGM_CYC * `EEPC_AUTO_NUM / `EEPC_AUTO_DEN;
wire [31:0] byte_lim_w = BYTE_CYC * `EEPC_AUTO_NUM / `EEPC_AUTO_DEN;
wire [31:0] blk_lim_w = BLOCK_CYC * `EEPC_AUTO_NUM / `EEPC_AUTO_DEN;
wire [31:0] bulk_lim_w = BULK_CYC * `EEPC_AUTO_NUM / `EEPC_AUTO_DEN;
reg [CW-1:0] auto_lim;
always @* begin
    case (mode)
        `EEPC_OP_PGM: auto_lim = pgm_lim_w[CW-1:0];
        `EEPC_OP_BYTE_ERS: auto_lim = byte_lim_w[CW-1:0];
        `EEPC_OP_BLK_ERS: auto_lim = blk_lim_w[CW-1:0];
        default: auto_lim = bulk_lim_w[CW-1:0];
    endcase
end

wire auto_end = hv_pulse_enable & auto_mode & (cnt >= auto_lim - 1'b1);
wire ctl_wr = wr & ctl_hit & ~(bus_latch_ctl & ~lat_valid);
wire man_clr = ctl_wr & hv_pulse_enable & ~pwdata[`EEPC_HV];
wire hv_end = auto_end | man_clr;
// A manual pulse shorter than the self-timed limit does not take effect.
wire op_go = hv_end & ~fail & (auto_end | (cnt >= auto_lim));
// A pulse may start only from a latched, valid target.
wire hv_start = ctl_wr & ~hv_pulse_enable & pwdata[`EEPC_HV] &
                bus_latch_ctl & lat_valid;
// The target latch is frozen while the pulse runs.
wire lat_wr = bus_latch_ctl & ~hv_pulse_enable & wr & (arr_hit | shd_hit);
wire lat_rd = bus_latch_ctl & ~hv_pulse_enable & rd & arr_hit;
wire lat_drop = ctl_wr & ~hv_pulse_enable & ~pwdata[`EEPC_LATCH];

////////////////////////////////////////////////////////////////////////////
// Control register, latches and timer.

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        hv_pulse_enable <= 1'b0;
        auto_mode <= 1'b0;
        bus_latch_ctl <= 1'b0;
        op_mode_sel_lo <= 1'b0;
        op_mode_sel_hi <= 1'b0;
        spare <= 1'b0;
    end else begin
        if (auto_end) begin
            hv_pulse_enable <= 1'b0;
        end
        if (ctl_wr) begin
            spare <= pwdata[`EEPC_SPARE];
            if (!hv_pulse_enable) begin
                auto_mode <= pwdata[`EEPC_AUTO];
                op_mode_sel_lo <= pwdata[`EEPC_MODE_LO];
                op_mode_sel_hi <= pwdata[`EEPC_MODE_HI];
                bus_latch_ctl <= pwdata[`EEPC_LATCH];
                if (hv_start) begin
                    hv_pulse_enable <= 1'b1;
                end
            end else if (!pwdata[`EEPC_HV]) begin
                hv_pulse_enable <= 1'b0;
            end
        end
    end
end

// The pulse timer counts up from the cycle after the enable is set.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cnt <= {CW{1'b0}};
    end else if (hv_pulse_enable) begin
        cnt <= cnt + 1'b1;
    end else begin
        cnt <= {CW{1'b0}};
    end
end

// An array read during the pulse spoils it; the mark stays until the
// next pulse starts, so software can tell that the last operation was lost.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        fail <= 1'b0;
    end else if (hv_pulse_enable & rd & arr_hit & !hv_end) begin
        fail <= 1'b1;
    end else if (hv_start) begin
        fail <= 1'b0;
    end
end

// The protect flags follow the shadow only when it is read, so a newly
// programmed shadow takes effect at a moment software chooses.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        block_protect_flag <= `EEPC_PROT_RST;
    end else if (rd & shd_hit) begin
        block_protect_flag <= shadow[`EEPC_PROT_W-1:0];
    end
end

// Target latch: the last valid access replaces any earlier one.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        lat_valid <= 1'b0;
        lat_shadow <= 1'b0;
        lat_idx <= 9'h000;
        lat_data <= 8'h00;
    end else if (lat_wr) begin
        lat_valid <= 1'b1;
        lat_shadow <= shd_hit;
        lat_idx <= idx;
        lat_data <= pwdata[7:0];
    end else if (lat_rd) begin
        lat_valid <= 1'b1;
        lat_shadow <= 1'b0;
        lat_idx <= idx;
    end else if (lat_drop) begin
        lat_valid <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// Array and shadow update. nothing here touches the latch bit.

wire arr_op = op_go & ~lat_shadow;
wire [1:0] tgt_blk = lat_idx[`EEPC_BLK_HI:`EEPC_BLK_LO];

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        shadow <= `EEPC_SHADOW_RST;
    end else if (op_go & lat_shadow) begin
        if (mode == `EEPC_OP_PGM) begin
            shadow <= shadow & lat_data;
        end else begin
            shadow <= `EEPC_ERASED;
        end
    end
end

// Each byte decides alone whether the latched operation reaches it,
// which keeps the decode shallow at the cost of one compare per byte.
genvar g;
generate
    for (g = 0; g < `EEPC_DEPTH; g = g + 1) begin : g_byte
        wire is_tgt = (lat_idx == g);
        wire in_blk = (tgt_blk == g / `EEPC_BLK_BYTES);
        wire locked = block_protect_flag[g / `EEPC_BLK_BYTES];
        wire do_pgm = arr_op & (mode == `EEPC_OP_PGM) & is_tgt;
        wire do_ers = arr_op & (((mode == `EEPC_OP_BYTE_ERS) & is_tgt) |
                      ((mode == `EEPC_OP_BLK_ERS) & in_blk) |
                      (mode == `EEPC_OP_BULK_ERS));
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mem[g] <= `EEPC_ERASED;
            end else if (do_pgm & ~locked) begin
                mem[g] <= mem[g] & lat_data;
            end else if (do_ers & ~locked) begin
                mem[g] <= `EEPC_ERASED;
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// APB answer: one wait state, so read data and error come from flops.

reg [7:0] rd_byte;
always @* begin
    rd_byte = 8'h00;
    if (arr_hit) begin
        // While the buses are latched the array itself is not visible.
        if (bus_latch_ctl) begin
            rd_byte = lat_data;
        end else begin
            rd_byte = mem[idx];
        end
    end else if (ctl_hit) begin
        rd_byte = {spare, lat_valid, fail, op_mode_sel_hi, op_mode_sel_lo,
                   bus_latch_ctl, auto_mode, hv_pulse_enable};
    end else if (shd_hit) begin
        rd_byte = shadow;
    end else if (prt_hit) begin
        rd_byte = {4'h0, block_protect_flag};
    end
end

wire acc_wait = psel & penable & ~pready;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= acc_wait;
        pslverr <= acc_wait & ~mapped;
    end
end

// Read data holds until the next access; write accesses return zero.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
    end else if (acc_wait) begin
        prdata <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
    end
end

// The pump output drops at the edge that ends the pulse, so high voltage
// is never shown for a cycle after the enable has gone.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        hv_pump_on <= 1'b0;
    end else begin
        hv_pump_on <= hv_pulse_enable & ~hv_end;
    end
end

endmodule // eepc_top

// ---- rtl/eepc_regs.vh ----
`ifndef EEPC_REGS_VH
`define EEPC_REGS_VH

// APB byte offsets.
`define EEPC_OFS_CTRL 12'h000
`define EEPC_OFS_SHADOW 12'h004
`define EEPC_OFS_PROT 12'h008
`define EEPC_ARR_SEL_BIT 11
`define EEPC_IDX_HI 10
`define EEPC_IDX_LO 2

// Array geometry: byte count, block size and block index bits.
`define EEPC_DEPTH 512
`define EEPC_BLK_BYTES 128
`define EEPC_BLK_HI 8
`define EEPC_BLK_LO 7
`define EEPC_PROT_W 4

// Control register fields.
`define EEPC_HV 0
`define EEPC_AUTO 1
`define EEPC_LATCH 2
`define EEPC_MODE_LO 3
`define EEPC_MODE_HI 4
`define EEPC_FAIL 5
`define EEPC_VALID 6
`define EEPC_SPARE 7

// Operation codes of the two-bit mode field.
`define EEPC_OP_PGM 2'h0
`define EEPC_OP_BYTE_ERS 2'h1
`define EEPC_OP_BLK_ERS 2'h2
`define EEPC_OP_BULK_ERS 2'h3

// Reset values.
`define EEPC_ERASED 8'hFF
`define EEPC_SHADOW_RST 8'hF0
`define EEPC_PROT_RST 4'h0

// Self-timed limit as a fraction of the manual time.
`define EEPC_AUTO_NUM 3
`define EEPC_AUTO_DEN 4

// Manual operation times in microseconds and the clock period.
`define EEPC_PGM_PULSE_US 10
`define EEPC_BYTE_ERASE_US 10
`define EEPC_BLOCK_ERASE_US 10
`define EEPC_BULK_ERASE_US 10
`define EEPC_CLK_NS 4

`endif

// ---- tb/eepc_sva.sv ----
module eepc_sva #(
    parameter int PGM_CYC = 40
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire hv_pump_on
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr_ctrl = psel && penable && pready && pwrite && paddr == 12'h000;
    logic auto_q;
    // Remembers the self-timed bit of the last control write, whether or not that write started the running pulse.
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            auto_q <= 1'b0;
        else if (wr_ctrl)
            auto_q <= pwdata[1];
    ////////////////////
    a_ready_wait: assert property (
        psel && !penable |=> !pready ##1 pready) else $error("late pready");
    a_ready_pulse: assert property (
        pready |=> !pready) else $error("pready held");
    a_err_gap: assert property (
        pready && !paddr[11] && paddr[10:2] > 9'h002 |-> pslverr)
        else $error("no error on hole");
    a_arr_ok: assert property (
        pready && paddr[11] |-> !pslverr) else $error("array error");
    a_rd_byte: assert property (
        pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits");
    a_pump_rise: assert property (
        $rose(hv_pump_on) |-> $past(wr_ctrl && pwdata[0], 2))
        else $error("pump without enable");
    a_pump_fall: assert property (
        $fell(hv_pump_on) && !auto_q |-> $past(wr_ctrl && !pwdata[0], 1))
        else $error("manual pump dropped");
    a_pump_auto: assert property (
        $rose(hv_pump_on) && auto_q |-> ##[1:PGM_CYC] !hv_pump_on)
        else $error("auto pulse too long");
    cover property ($rose(hv_pump_on) && auto_q);
    cover property ($fell(hv_pump_on) && !auto_q);
    cover property (pready && pslverr);
endmodule // eepc_sva

bind eepc_top eepc_sva #(.PGM_CYC(PGM_CYC)) u_sva (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hv_pump_on(hv_pump_on));

// ---- tb/eepc_host.sv ----
module eepc_host (
    input wire pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // The request stands untouched until pready is seen at a rising edge.
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // eepc_host

// ---- tb/eepc_top_tb_top.sv ----
module eepc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [11:0] a; logic [31:0] d; logic e;} eepc_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    wire psel, penable, pwrite, pready, pslverr, hv_pump_on;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    logic [31:0] rd;
    logic er;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    eepc_row_t rows[6] = '{'{12'h000, 32'h0, 1'b0}, '{12'h004, 32'hF0, 1'b0},
        '{12'h008, 32'h0, 1'b0}, '{12'h800, 32'hFF, 1'b0},
        '{12'hFFC, 32'hFF, 1'b0}, '{12'h00C, 32'h0, 1'b1}};
    always #2 pclk = ~pclk;
    eepc_top #(.PGM_CYC(40), .BYTE_CYC(40), .BLOCK_CYC(40), .BULK_CYC(40))
        dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hv_pump_on(hv_pump_on));
    eepc_host host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    ////////////////////
    task complete_run();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        host.xfer(w, a, d, rd, er);
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // A decoy write goes first, so the target must replace it.
    task op(input logic [7:0] c, input logic [11:0] a, input logic [7:0] d);
        int n;
        bus(1'b1, 12'h000, {24'h0, c | 8'h04});
        bus(1'b1, 12'h9FC, 32'h0);
        bus(1'b1, a, {24'h0, d});
        if (a[11])
            rdchk(a, {24'h0, d});
        bus(1'b1, 12'h000, {24'h0, c | 8'h05});
        n = 0;
        if (c[1]) begin
            do begin
                bus(1'b0, 12'h000, 32'h0);
                n++;
            end while (rd[0] && n < 30);
        end else begin
            repeat (40) @(posedge pclk);
            chk({31'h0, hv_pump_on}, 32'h1);
            bus(1'b1, 12'h000, 32'h0);
            repeat (4) @(posedge pclk);
        end
        rdchk(12'h000, {24'h0, c | 8'h44});
        bus(1'b1, 12'h000, 32'h0);
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            rdchk(rows[i].a, rows[i].d);
            chk({31'h0, er}, {31'h0, rows[i].e});
        end
        $display("reset values done");
        bus(1'b1, 12'h000, 32'h1);
        rdchk(12'h000, 32'h0);
        bus(1'b1, 12'h000, 32'h4);
        bus(1'b1, 12'h008, 32'h0);
        bus(1'b1, 12'h000, 32'h5);
        rdchk(12'h000, 32'h4);
        bus(1'b1, 12'h9FC, 32'hFF);
        bus(1'b1, 12'h000, 32'h0);
        $display("refusals done");
        op(8'h00, 12'h810, 8'hFE);
        op(8'h00, 12'h810, 8'hFD);
        rdchk(12'h810, 32'hFC);
        rdchk(12'h9FC, 32'hFF);
        op(8'h0A, 12'h810, 8'h00);
        rdchk(12'h810, 32'hFF);
        op(8'h00, 12'h800, 8'h00);
        op(8'h00, 12'hA00, 8'h00);
        op(8'h12, 12'h804, 8'h55);
        rdchk(12'h800, 32'hFF);
        rdchk(12'hA00, 32'h0);
        op(8'h18, 12'h900, 8'h00);
        rdchk(12'hA00, 32'hFF);
        $display("program and erase done");
        op(8'h0A, 12'h004, 8'h00);
        bus(1'b0, 12'h004, 32'h0);
        rdchk(12'h008, 32'hF);
        op(8'h02, 12'h900, 8'h00);
        rdchk(12'h900, 32'hFF);
        $display("protection done");
        complete_run();
    end
endmodule // eepc_top_tb_top
